/* dv/rbf_backplane_model.sv */
`timescale 1ns/1ps
module rbf_backplane_model (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Byte stream from the block
  input logic bp_valid,
  output logic bp_ready,
  input rbf_pkg::rbf_word_t bp_data,
  // Controls from the bench
  input logic stall,
  input logic sync_low,
  input logic sync_pulse,
  // Frame boundary towards the block
  output logic sync_o
);
  // ----------------------------------------------------------------
  // Receiving side
  // ----------------------------------------------------------------
  rbf_pkg::rbf_word_t words[$];

  // Boundary idles inactive, pulse drives active level
  assign sync_o = sync_low ^ sync_pulse;

  // Accept unless the bench asks for a stall
  assign bp_ready = presetn & ~stall;

  // Keep every accepted word in order
  always @(posedge pclk) begin
    if (bp_valid === 1'h1 && bp_ready === 1'h1) begin
      words.push_back(bp_data);
    end
  end
endmodule

/* dv/rbf_top_bench.sv */
`timescale 1ns/1ps
module rbf_top_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_clk = 1'h0;
  logic line_dat = 1'h0;
  logic line_run = 1'h0;
  logic sck_o, sck_oe, sck_w, fb_o, fb_oe, fb_w, fb_far, ch_o;
  logic bp_valid, bp_ready;
  logic [4:0] id_o;
  rbf_pkg::rbf_word_t bp_data;
  logic stall = 1'h1;
  logic sync_low = 1'h0;
  logic sync_pulse = 1'h0;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic err;
  localparam logic [11:0] RIC = rbf_pkg::RIC_OFFS;
  localparam logic [11:0] MODE = rbf_pkg::MODE_OFFS;
  localparam logic [11:0] FM = rbf_pkg::FMASK_OFFS;
  localparam logic [11:0] ST = rbf_pkg::STAT_OFFS;

  // Clock, and line clock of unrelated phase, data on falling edge
  always #2.5 pclk = ~pclk;
  initial begin
    #7;
    forever begin
      #40;
      if (line_clk) line_dat <= ~line_dat;
      line_clk <= line_run ? ~line_clk : 1'h0;
    end
  end

  // Pin levels from all drivers
  assign sck_w = sck_oe ? sck_o : 1'h1;
  assign fb_w = fb_oe ? fb_o : fb_far;

  rbf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line_clock(line_clk), .rx_line_data(line_dat),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .frame_boundary_signal_i(fb_w),
    .frame_boundary_signal_o(fb_o), .frame_boundary_signal_oe(fb_oe),
    .channel_clock_pin_o(ch_o), .timeslot_id_pins_o(id_o),
    .bp_valid(bp_valid), .bp_ready(bp_ready), .bp_data(bp_data));

  rbf_backplane_model sink_u (.pclk(pclk), .presetn(presetn),
    .bp_valid(bp_valid), .bp_ready(bp_ready), .bp_data(bp_data),
    .stall(stall), .sync_low(sync_low), .sync_pulse(sync_pulse),
    .sync_o(fb_far));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1, "apb hang");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic pulse();
    sync_pulse <= 1'h1;
    cyc(4);
    sync_pulse <= 1'h0;
    cyc(10);
  endtask

  task automatic fb_rise();
    logic p;
    int k;
    p = 1'h1;
    k = 0;
    while (!(fb_o === 1'h1 && p === 1'h0) && k < 7000) begin
      p = fb_o;
      @(posedge pclk);
      k++;
    end
    if (k >= 7000) chk(32'h0, 32'h1, "no frame");
  endtask

  // Rising edges per frame: sck, channel clock, id3, id4
  task automatic cnt_frame(output int n[4]);
    logic [3:0] p, s;
    logic pf;
    n = '{0, 0, 0, 0};
    fb_rise();
    pf = 1'h1;
    p = {id_o[4], id_o[3], ch_o, sck_o};
    for (int k = 0; k < 4000; k++) begin
      @(posedge pclk);
      s = {id_o[4], id_o[3], ch_o, sck_o};
      for (int j = 0; j < 4; j++) if (s[j] === 1'h1 && p[j] === 1'h0) n[j]++;
      p = s;
      if (fb_o === 1'h1 && pf === 1'h0) break;
      pf = fb_o;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'h0, RIC, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'h1, RIC, 32'hFF);
    apb(1'h0, RIC, 32'h0);
    chk(rd, 32'hB0, "ctrl fields");
    apb(1'h1, RIC, 32'h40);
    apb(1'h0, RIC, 32'h0);
    chk(rd, 32'h0, "reserved bit");
    apb(1'h0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
  endtask

  task automatic t_clocks();
    logic [7:0] ct[4] = '{8'h00, 8'h20, 8'h10, 8'h90};
    logic [31:0] fm[4] = '{32'h0, 32'h0, 32'h1, 32'h5};
    int es[4] = '{193, 192, 193, 193};
    int ec[4] = '{24, -1, 8, 2};
    int n[4];
    stall <= 1'h0;
    line_run <= 1'h1;
    apb(1'h1, MODE, 32'h2);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, FM, fm[i]);
      apb(1'h1, RIC, 32'(ct[i]));
      cnt_frame(n);
      chk({31'h0, sck_oe}, 32'h1, "sck oe");
      chk({31'h0, fb_oe}, 32'h1, "fb oe");
      chk(32'(n[0]), 32'(es[i]), "sck rises");
      if (ec[i] >= 0) chk(32'(n[1]), 32'(ec[i]), "ch rises");
      if (i >= 2) chk(32'(n[2]), 32'h1, "8k rises");
      if (i >= 2) chk(32'(n[3]), 32'd193, "rclk rises");
    end
  endtask

  task automatic t_static();
    logic [4:0] v;
    line_run <= 1'h0;
    apb(1'h1, MODE, 32'h0);
    apb(1'h1, RIC, 32'h80);
    cyc(20);
    apb(1'h0, ST, 32'h0);
    chk(32'(id_o), 32'(rd[4:0]), "id frac off");
    chk(32'(rd[6]), 32'h1, "sck pin in");
    apb(1'h1, RIC, 32'h0);
    cyc(4);
    chk(32'(id_o), 32'(rd[4:0]), "id parallel");
    apb(1'h1, MODE, 32'h1);
    cyc(4);
    v = id_o;
    apb(1'h1, RIC, 32'h10);
    cyc(4);
    chk(32'(id_o), 32'(v), "hs enable ignored");
  endtask

  task automatic t_hs();
    apb(1'h1, RIC, 32'h0);
    line_run <= 1'h1;
    cyc(200);
    line_run <= 1'h0;
    cyc(20);
    pulse();
    apb(1'h0, ST, 32'h0);
    chk(32'(rd[5:0]), 32'h20, "realign high");
    sync_low <= 1'h1;
    apb(1'h1, RIC, 32'h20);
    line_run <= 1'h1;
    cyc(200);
    line_run <= 1'h0;
    cyc(20);
    apb(1'h0, ST, 32'h0);
    chk(32'(rd[5]), 32'h0, "moved off framing");
    pulse();
    apb(1'h0, ST, 32'h0);
    chk(32'(rd[5:0]), 32'h20, "realign low");
  endtask

  task automatic t_buffer();
    rbf_pkg::rbf_word_t w0, w1;
    int b;
    sync_low <= 1'h0;
    apb(1'h1, MODE, 32'h0);
    apb(1'h1, RIC, 32'h0);
    stall <= 1'h1;
    line_run <= 1'h1;
    apb(1'h1, ST, 32'h100);
    cyc(700);
    chk({31'h0, bp_valid}, 32'h1, "valid held");
    apb(1'h0, ST, 32'h0);
    chk(32'(rd[8]), 32'h1, "overflow set");
    b = sink_u.words.size();
    stall <= 1'h0;
    for (int k = 0; k < 50 && sink_u.words.size() < b + 2; k++) cyc(1);
    chk(32'(sink_u.words.size() >= b + 2), 32'h1, "drain");
    w0 = sink_u.words[b];
    w1 = sink_u.words[b + 1];
    chk(32'(w1.chan), w0.chan == 5'h17 ? 32'h0 : 32'(w0.chan) + 32'h1,
        "slot order");
    chk(32'(w0.data == 8'hAA || w0.data == 8'h55), 32'h1, "byte");
    apb(1'h1, ST, 32'h100);
    apb(1'h0, ST, 32'h0);
    chk(32'(rd[8]), 32'h0, "overflow clear");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_clocks();
    t_static();
    t_hs();
    t_buffer();
    print_verdict();
  end

  // Cut a hang short
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
endmodule

/* rtl/rbf_buf.sv */
`timescale 1ns/1ps
module rbf_buf #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("rbf_buf: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end

endmodule

/* rtl/rbf_pkg.sv */
package rbf_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] RIC_OFFS = 12'h000;
  localparam logic [11:0] MODE_OFFS = 12'h004;
  localparam logic [11:0] FMASK_OFFS = 12'h008;
  localparam logic [11:0] STAT_OFFS = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RIC_RESET = 8'h00;
  localparam logic [7:0] RIC_WMASK = 8'hB0;
  localparam int MODE_HS_BIT = 0;
  localparam int MODE_SCK_OUT_BIT = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [23:0] FMASK_RESET = 24'h000000;
  localparam int STAT_CHAN_LSB = 0;
  localparam int STAT_OVH_BIT = 5;
  localparam int STAT_SCK_IN_BIT = 6;
  localparam int STAT_OVF_BIT = 8;

  // ----------------------------------------------------------------
  // Frame timing counts (in slots and line bits)
  // ----------------------------------------------------------------
  localparam logic [4:0] LAST_SLOT = 5'h17;
  localparam logic [4:0] HALF_SLOTS = 5'h0C;
  localparam logic [2:0] LAST_SBIT = 3'h7;
  localparam logic [2:0] CHAN_SER_BITS = 3'h5;
  localparam logic [2:0] CHAN_MSB = 3'h4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frac_clock_select;
    logic rsvd;
    logic payload_clock_or_sync_polarity;
    logic frac_signaling_enable;
    logic [3:0] unused;
  } rbf_ric_t;

  typedef struct packed {
    logic [4:0] chan;
    logic [7:0] data;
  } rbf_word_t;

endpackage

/* rtl/rbf_top.sv */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// R01 - Control bits 7, 5, 4 used, reset zero
// R02 - Select 0: channel clock clocks fractional data
// R03 - Select 1: serial clock clocks, channel pin enables
// R04 - Base, fractional off: id pins show slot number
// R05 - Base, plain field: continuous serial clock out
// R06 - Base, payload field: clock gapped on overhead
// R07 - High speed: bit 5 sets boundary polarity
// R08 - Fractional enable ignored outside base rate
// R09 - Base, enable low: parallel channel number
// R10 - Enable high: signaling, data, serial number, 8k
// R11 - Enable high: id pin 4 gives line clock
// R12 - Reserved bit reads zero, writes ignored
module rbf_top (
  // APB clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive line stream
  input logic rx_line_clock,
  input logic rx_line_data,
  // Serial clock pin
  input logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  // Frame boundary pin
  input logic frame_boundary_signal_i,
  output logic frame_boundary_signal_o,
  output logic frame_boundary_signal_oe,
  // Channel clock and time slot identifier pins
  output logic channel_clock_pin_o,
  output logic [4:0] timeslot_id_pins_o,
  // Backplane byte stream
  output logic bp_valid,
  input logic bp_ready,
  output rbf_pkg::rbf_word_t bp_data
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_in;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic rck;
  logic dat;
  logic fbi;
  logic sck_in;

  assign sync_in = {serial_clock_pin_i, frame_boundary_signal_i,
                    rx_line_data, rx_line_clock};

  // Two flops on every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= sync_in;
      s2_r <= s1_r;
    end
  end

  assign rck = s2_r[0];
  assign dat = s2_r[1];
  assign fbi = s2_r[2];
  assign sck_in = s2_r[3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rbf_pkg::rbf_ric_t ric_r;
  logic [1:0] mode_r;
  logic [23:0] fmask_r;
  logic ovf_r;
  logic [31:0] prdata_r;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic ovf_set;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == rbf_pkg::RIC_OFFS) |
                  (paddr == rbf_pkg::MODE_OFFS) |
                  (paddr == rbf_pkg::FMASK_OFFS) |
                  (paddr == rbf_pkg::STAT_OFFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  // Control register writes, reserved and unused bits masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ric_r <= rbf_pkg::rbf_ric_t'(rbf_pkg::RIC_RESET); // R01
    end else if (wr_acc && paddr == rbf_pkg::RIC_OFFS) begin
      ric_r <= rbf_pkg::rbf_ric_t'(pwdata[7:0] & rbf_pkg::RIC_WMASK); // R12
    end
  end

  // Mode and fractional slot mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= rbf_pkg::MODE_RESET;
      fmask_r <= rbf_pkg::FMASK_RESET;
    end else if (wr_acc) begin
      if (paddr == rbf_pkg::MODE_OFFS) begin
        mode_r <= pwdata[1:0];
      end
      if (paddr == rbf_pkg::FMASK_OFFS) begin
        fmask_r <= pwdata[23:0];
      end
    end
  end

  // Overflow flag, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_r <= 1'b1;
    end else if (wr_acc && paddr == rbf_pkg::STAT_OFFS &&
                 pwdata[rbf_pkg::STAT_OVF_BIT]) begin
      ovf_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Frame position
  // ----------------------------------------------------------------
  logic rck_d_r;
  logic fb_act_d_r;
  logic bit_en;
  logic fb_act;
  logic sync_edge;
  logic hs;
  logic base;
  logic frac_on;
  logic ovh_r;
  logic [4:0] slot_r;
  logic [2:0] sbit_r;

  assign hs = mode_r[rbf_pkg::MODE_HS_BIT];
  assign base = ~hs;
  assign frac_on = base & ric_r.frac_signaling_enable; // R08
  assign bit_en = rck & ~rck_d_r;
  assign fb_act = fbi ^ ric_r.payload_clock_or_sync_polarity; // R07
  assign sync_edge = hs & fb_act & ~fb_act_d_r; // R07

  // Edge history of line clock and boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rck_d_r <= 1'b0;
      fb_act_d_r <= 1'b0;
    end else begin
      rck_d_r <= rck;
      fb_act_d_r <= fb_act;
    end
  end

  // Framing bit, slot and bit counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovh_r <= 1'b1;
      slot_r <= 5'h00;
      sbit_r <= 3'h0;
    end else if (sync_edge) begin
      ovh_r <= 1'b1; // R07
      slot_r <= 5'h00;
      sbit_r <= 3'h0;
    end else if (bit_en) begin
      if (ovh_r) begin
        ovh_r <= 1'b0;
        slot_r <= 5'h00;
        sbit_r <= 3'h0;
      end else if (sbit_r == rbf_pkg::LAST_SBIT) begin
        sbit_r <= 3'h0;
        if (slot_r == rbf_pkg::LAST_SLOT) begin
          ovh_r <= 1'b1;
        end else begin
          slot_r <= slot_r + 5'h01;
        end
      end else begin
        sbit_r <= sbit_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data capture and backplane buffer
  // ----------------------------------------------------------------
  logic [7:0] shreg_r;
  logic bitval_r;
  logic sig_r;
  logic push_r;
  rbf_pkg::rbf_word_t push_word_r;
  logic buf_ready;

  // Payload bits into bytes, last bit of slot kept as signaling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_r <= 8'h00;
      bitval_r <= 1'b0;
      sig_r <= 1'b0;
      push_r <= 1'b0;
      push_word_r <= '0;
    end else begin
      push_r <= bit_en & ~ovh_r & (sbit_r == rbf_pkg::LAST_SBIT);
      if (bit_en) begin
        bitval_r <= dat;
      end
      if (bit_en && !ovh_r) begin
        shreg_r <= {shreg_r[6:0], dat};
        if (sbit_r == rbf_pkg::LAST_SBIT) begin
          sig_r <= dat;
          push_word_r.chan <= slot_r;
          push_word_r.data <= {shreg_r[6:0], dat};
        end
      end
    end
  end

  // Line cannot stall; a refused byte is flagged
  assign ovf_set = push_r & ~buf_ready;

  rbf_buf #(
    .WIDTH($bits(rbf_pkg::rbf_word_t)),
    .DEPTH(2)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_r),
    .in_ready(buf_ready),
    .in_data(push_word_r),
    .out_valid(bp_valid),
    .out_ready(bp_ready),
    .out_data(bp_data)
  );

  // ----------------------------------------------------------------
  // Backplane pins
  // ----------------------------------------------------------------
  logic frac_slot;
  logic khz8;
  logic chan_bit;
  logic frac_dat;
  logic serclk_o_r;
  logic serclk_oe_r;
  logic fb_o_r;
  logic fb_oe_r;
  logic chclk_r;
  logic [4:0] tsid_r;

  assign frac_slot = ~ovh_r & fmask_r[slot_r];
  assign khz8 = ovh_r | (slot_r < rbf_pkg::HALF_SLOTS);
  assign chan_bit = (sbit_r < rbf_pkg::CHAN_SER_BITS) ?
                    slot_r[rbf_pkg::CHAN_MSB - sbit_r] : 1'b0;
  assign frac_dat = frac_slot & bitval_r;

  // Serial clock and frame boundary outputs
  // Pin clocks use the delayed line clock, in step with the counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serclk_o_r <= 1'b0;
      serclk_oe_r <= 1'b0;
      fb_o_r <= 1'b0;
      fb_oe_r <= 1'b0;
    end else begin
      serclk_oe_r <= base & mode_r[rbf_pkg::MODE_SCK_OUT_BIT];
      if (ric_r.payload_clock_or_sync_polarity) begin
        serclk_o_r <= base & rck_d_r & ~ovh_r; // R06
      end else begin
        serclk_o_r <= base & rck_d_r; // R05
      end
      fb_oe_r <= base & mode_r[rbf_pkg::MODE_SCK_OUT_BIT];
      fb_o_r <= base & ovh_r;
    end
  end

  // Channel clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chclk_r <= 1'b0;
    end else if (frac_on && ric_r.frac_clock_select) begin
      chclk_r <= frac_slot; // R03
    end else if (frac_on) begin
      chclk_r <= rck_d_r & frac_slot; // R02
    end else begin
      chclk_r <= rck_d_r & ~ovh_r & (sbit_r == 3'h0);
    end
  end

  // Time slot identifier pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsid_r <= 5'h00;
    end else if (frac_on) begin
      tsid_r <= {rck_d_r, khz8, chan_bit, frac_dat, sig_r}; // R10 R11
    end else if (hs) begin
      tsid_r <= {rck_d_r, slot_r[3:1], sig_r}; // R08
    end else begin
      tsid_r <= slot_r; // R04 R09
    end
  end

  assign serial_clock_pin_o = serclk_o_r;
  assign serial_clock_pin_oe = serclk_oe_r;
  assign frame_boundary_signal_o = fb_o_r;
  assign frame_boundary_signal_oe = fb_oe_r;
  assign channel_clock_pin_o = chclk_r;
  assign timeslot_id_pins_o = tsid_r;

  // ----------------------------------------------------------------
  // Register read data, set up in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= 32'h00000000;
      unique case (paddr)
        rbf_pkg::RIC_OFFS: prdata_r[7:0] <= ric_r; // R12
        rbf_pkg::MODE_OFFS: prdata_r[1:0] <= mode_r;
        rbf_pkg::FMASK_OFFS: prdata_r[23:0] <= fmask_r;
        rbf_pkg::STAT_OFFS: begin
          prdata_r[rbf_pkg::STAT_CHAN_LSB +: 5] <= slot_r;
          prdata_r[rbf_pkg::STAT_OVH_BIT] <= ovh_r;
          prdata_r[rbf_pkg::STAT_SCK_IN_BIT] <= sck_in;
          prdata_r[rbf_pkg::STAT_OVF_BIT] <= ovf_r;
        end
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ric_write;
    wr_acc && paddr == rbf_pkg::RIC_OFFS;
  endsequence

  sequence s_sync_edge;
    hs && !fb_act ##1 hs && fb_act;
  endsequence

  sequence s_frac_steady;
    frac_on ##1 frac_on;
  endsequence

  property p_ric_write;
    s_ric_write |=> ric_r == ($past(pwdata[7:0]) & rbf_pkg::RIC_WMASK);
  endproperty
  a_ric_write: assert property (p_ric_write) // R01
    else $error("control register write not stored");

  property p_rsvd_read;
    psel && penable && !pwrite && paddr == rbf_pkg::RIC_OFFS |->
      prdata[6] == 1'b0 && prdata[3:0] == 4'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) // R12
    else $error("reserved control bit read nonzero");

  property p_chclk_gap;
    frac_on && !ric_r.frac_clock_select && !frac_slot ##1
      frac_on && !ric_r.frac_clock_select |-> !channel_clock_pin_o;
  endproperty
  a_chclk_gap: assert property (p_chclk_gap) // R02
    else $error("channel clock pulsed outside fractional slot");

  property p_chclk_enable;
    frac_on && ric_r.frac_clock_select ##1 frac_on |->
      channel_clock_pin_o == $past(frac_slot);
  endproperty
  a_chclk_enable: assert property (p_chclk_enable) // R03
    else $error("channel pin not acting as fractional enable");

  property p_slot_number;
    !frac_on && base ##1 !frac_on && base |->
      timeslot_id_pins_o == $past(slot_r);
  endproperty
  a_slot_number: assert property (p_slot_number) // R04 R09
    else $error("id pins not showing slot number");

  property p_serclk_plain;
    (base && !ric_r.payload_clock_or_sync_polarity) [*2] |->
      serial_clock_pin_o == $past(rck_d_r);
  endproperty
  a_serclk_plain: assert property (p_serclk_plain) // R05
    else $error("serial clock not continuous");

  property p_serclk_gap;
    base && ric_r.payload_clock_or_sync_polarity && ovh_r ##1
      base && ric_r.payload_clock_or_sync_polarity |-> !serial_clock_pin_o;
  endproperty
  a_serclk_gap: assert property (p_serclk_gap) // R06
    else $error("serial clock pulsed on overhead bit");

  property p_sync_align;
    s_sync_edge |=> ovh_r && slot_r == 5'h00 && sbit_r == 3'h0;
  endproperty
  a_sync_align: assert property (p_sync_align) // R07
    else $error("frame not aligned to active boundary edge");

  property p_hs_ignore;
    hs ##1 hs |-> timeslot_id_pins_o[3:1] == $past(slot_r[3:1]) &&
      timeslot_id_pins_o[4] == $past(rck_d_r);
  endproperty
  a_hs_ignore: assert property (p_hs_ignore) // R08
    else $error("fractional enable acted in high speed mode");

  property p_frac_pins;
    s_frac_steady |-> timeslot_id_pins_o[3] == $past(khz8) &&
      timeslot_id_pins_o[0] == $past(sig_r);
  endproperty
  a_frac_pins: assert property (p_frac_pins) // R10
    else $error("fractional pin map wrong");

  property p_rclk_pin;
    s_frac_steady |-> timeslot_id_pins_o[4] == $past(rck_d_r);
  endproperty
  a_rclk_pin: assert property (p_rclk_pin) // R11
    else $error("id pin 4 not carrying line clock");

endmodule
